// ===== rtl/adc_seq_defines.svh
// timing counts and field sizes for the conversion sequencer
// assumes core_clk at 40 MHz (25 ns)
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH
`define CLK_PERIOD_PS      25000
`define POWERUP_TIME_PS    1500000
`define CONV_TIME_PS       5000000
`define ACQ_TIME_PS        100000
// least times round up
`define POWERUP_CYCLES     ((`POWERUP_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// longest time rounds down
`define CONV_CYCLES        (`CONV_TIME_PS / `CLK_PERIOD_PS)
`define ACQ_CYCLES         ((`ACQ_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RESULT_BITS        8
`define SAR_STEPS          8
`define SHIFT_BITS         8
`define RESULT_RESET       8'h00
`endif

// ===== rtl/adc_seq_pkg.sv
// types for the conversion sequencer
package adc_seq_pkg;
   typedef enum logic [4:0] {
      ST_PDOWN   = 5'b00001,
      ST_WAKE    = 5'b00010,
      ST_TRACK   = 5'b00100,
      ST_CONVERT = 5'b01000,
      ST_DONE    = 5'b10000
   } seq_state_e;
   typedef struct packed {
      logic       valid;
      logic [7:0] code;
   } result_s;
endpackage

// ===== rtl/adc_serial_port.sv
// serial shift-out on the host's serial clock domain
// assumes sclk stops outside reads; load request is a toggle from core domain
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"
module adc_serial_port
   import adc_seq_pkg::*;
(
   input  wire logic       sclk,
   input  wire logic       rst_n,
   input  wire logic       start_n_pin,
   input  wire logic       load_tgl,
   input  wire logic [7:0] load_code,
   output logic            busy_tgl,
   output logic            dout_o,
   output logic            dout_oe
);
   logic [7:0] shift_r;
   logic [3:0] cnt_r;
   logic       armed_r;
   logic       ld_s1_r, ld_s2_r, ld_seen_r;
   logic       busy_r;
   logic       cs_s1_r, cs_s2_r, cs_d_r;
   logic       cs_rise;

   // start pin and load toggle synchronised into sclk domain
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         ld_s1_r <= 1'b0;
         ld_s2_r <= 1'b0;
         cs_s1_r <= 1'b0;
         cs_s2_r <= 1'b0;
         cs_d_r  <= 1'b0;
      end else begin
         ld_s1_r <= load_tgl;
         ld_s2_r <= ld_s1_r;
         cs_s1_r <= start_n_pin;
         cs_s2_r <= cs_s1_r;
         cs_d_r  <= cs_s2_r;
      end
   end
   assign cs_rise = cs_s2_r & ~cs_d_r;

   // rising start edge arms port and clears bit counter
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         shift_r   <= `RESULT_RESET;
         cnt_r     <= 4'h0;
         armed_r   <= 1'b0;
         ld_seen_r <= 1'b0;
         dout_o    <= 1'b0;
         busy_r    <= 1'b0;
      end else begin
         if (cs_rise) begin
            cnt_r   <= 4'h0;
            armed_r <= 1'b1;
            busy_r  <= 1'b0;
         end else if (armed_r && cnt_r < 4'(`SHIFT_BITS)) begin
            dout_o <= shift_r[7];
            shift_r <= {shift_r[6:0], 1'b0};
            cnt_r  <= cnt_r + 4'h1;
            busy_r <= (cnt_r != 4'(`SHIFT_BITS - 1));
            if (cnt_r == 4'(`SHIFT_BITS - 1)) armed_r <= 1'b0;
         end
         // result load between reads and on the arming edge
         if (!busy_r && !armed_r && (ld_s2_r != ld_seen_r)) begin
            shift_r   <= load_code;
            ld_seen_r <= ld_s2_r;
         end
      end
   end
   assign busy_tgl = ld_seen_r;

   // enabled half a clock ahead of first bit, released on falling edge of eighth clock
   always_ff @(negedge sclk or negedge rst_n) begin
      if (!rst_n) dout_oe <= 1'b0;
      else        dout_oe <= armed_r;
   end
endmodule
`default_nettype wire

// ===== rtl/adc_conversion_power_sequencer.sv
// conversion and power sequencer for an 8-bit successive-approximation converter
// assumes comparator input from analog array; host drives start pin and serial clock
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.svh"
module adc_conversion_power_sequencer
   import adc_seq_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       convert_start_n,
   input  wire logic       comparator_high,
   input  wire logic       sclk,
   output logic            powered,
   output logic            tracking,
   output logic [7:0]      dac_code,
   output logic [7:0]      result_code,
   output logic            dout_o,
   output logic            dout_oe
);
   localparam int PWR_N  = `POWERUP_CYCLES;
   localparam int CONV_N = `CONV_CYCLES;
   localparam int STEP_N = CONV_N / `SAR_STEPS;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser and edges
   logic cs_s1_r, cs_s2_r, cs_d_r;
   logic cs_rise, cs_fall;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_s1_r <= 1'b0;
         cs_s2_r <= 1'b0;
         cs_d_r  <= 1'b0;
      end else begin
         cs_s1_r <= convert_start_n;
         cs_s2_r <= cs_s1_r;
         cs_d_r  <= cs_s2_r;
      end
   end
   assign cs_rise = cs_s2_r & ~cs_d_r;
   assign cs_fall = ~cs_s2_r & cs_d_r;

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   seq_state_e  st_r, st_nxt;
   logic [7:0]  tmr_r, tmr_nxt;
   logic [2:0]  bit_r, bit_nxt;
   logic [7:0]  sar_r, sar_nxt;
   logic        pend_r, pend_nxt;
   result_s     res_r, res_nxt;
   logic        ld_tgl_r, ld_tgl_nxt;

   always_comb begin
      st_nxt     = st_r;
      tmr_nxt    = tmr_r;
      bit_nxt    = bit_r;
      sar_nxt    = sar_r;
      pend_nxt   = pend_r;
      res_nxt    = res_r;
      ld_tgl_nxt = ld_tgl_r;
      case (st_r)
         ST_PDOWN: begin
            if (cs_rise) begin
               st_nxt   = ST_WAKE;
               tmr_nxt  = 8'h00;
               pend_nxt = 1'b0;
            end
         end
         ST_WAKE: begin
            tmr_nxt = tmr_r + 8'h01;
            if (cs_fall) pend_nxt = 1'b1;
            if (tmr_r == 8'(PWR_N - 1)) begin
               st_nxt = (pend_r || cs_fall) ? ST_CONVERT : ST_TRACK;
               tmr_nxt = 8'h00;
               bit_nxt = 3'd7;
               sar_nxt = 8'h80;
            end
         end
         ST_TRACK: begin
            if (cs_fall) begin
               st_nxt  = ST_CONVERT;
               tmr_nxt = 8'h00;
               bit_nxt = 3'd7;
               sar_nxt = 8'h80;
            end
         end
         ST_CONVERT: begin // falling edges ignored here
            tmr_nxt = tmr_r + 8'h01;
            if (tmr_r == 8'(STEP_N - 1)) begin
               tmr_nxt = 8'h00;
               sar_nxt[bit_r] = ~comparator_high;
               if (bit_r != 3'd0) sar_nxt[bit_r - 3'd1] = 1'b1;
               else               st_nxt = ST_DONE;
               bit_nxt = bit_r - 3'd1;
            end
         end
         ST_DONE: begin
            res_nxt.code  = sar_r; // straight binary
            res_nxt.valid = 1'b1;
            ld_tgl_nxt    = ~ld_tgl_r;
            st_nxt        = cs_s2_r ? ST_TRACK : ST_PDOWN;
         end
         default: st_nxt = ST_PDOWN;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r     <= ST_PDOWN;
         tmr_r    <= 8'h00;
         bit_r    <= 3'd7;
         sar_r    <= 8'h00;
         pend_r   <= 1'b0;
         res_r    <= '0;
         ld_tgl_r <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         tmr_r    <= tmr_nxt;
         bit_r    <= bit_nxt;
         sar_r    <= sar_nxt;
         pend_r   <= pend_nxt;
         res_r    <= res_nxt;
         ld_tgl_r <= ld_tgl_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         powered     <= 1'b0;
         tracking    <= 1'b0;
         dac_code    <= 8'h00;
         result_code <= `RESULT_RESET;
      end else begin
         powered     <= (st_nxt != ST_PDOWN);
         tracking    <= (st_nxt == ST_TRACK) || (st_nxt == ST_PDOWN);
         dac_code    <= sar_nxt;
         result_code <= res_nxt.code;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial port in sclk domain
   logic port_dout, port_oe;
   adc_serial_port u_port (
      .sclk        (sclk),
      .rst_n       (rst_n),
      .start_n_pin (convert_start_n),
      .load_tgl    (ld_tgl_r),
      .load_code   (res_r.code),
      .busy_tgl    (),
      .dout_o      (port_dout),
      .dout_oe     (port_oe)
   );
   assign dout_o  = port_dout;
   assign dout_oe = port_oe;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   // power-up length counted apart from the sequencer timer
   logic [7:0] wake_cnt_r, wake_cnt_nxt;
   always_comb begin
      wake_cnt_nxt = (st_r == ST_WAKE) ? wake_cnt_r + 8'h01 : 8'h00;
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) wake_cnt_r <= 8'h00;
      else        wake_cnt_r <= wake_cnt_nxt;
   end
   a_reset_pdown: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r == ST_PDOWN && !cs_rise) |=> st_r == ST_PDOWN)
      else $error("left power-down without rising edge");
   a_wake_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r == ST_PDOWN && cs_rise) |=> st_r == ST_WAKE)
      else $error("rising edge did not wake");
   a_wake_stay: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r == ST_WAKE && wake_cnt_r != 8'(PWR_N - 1)) |=> st_r == ST_WAKE)
      else $error("power-up cut short");
   a_wake_time: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r == ST_WAKE && wake_cnt_r == 8'(PWR_N - 1)) |=> st_r != ST_WAKE)
      else $error("power-up time wrong");
   a_fall_starts: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r == ST_TRACK && cs_fall) |=> st_r == ST_CONVERT)
      else $error("falling edge did not start conversion");
   a_track_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r == ST_TRACK && !cs_fall) |=> st_r == ST_TRACK)
      else $error("left tracking without falling edge");
   a_conv_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(st_r == ST_CONVERT) |-> ##[1:200] st_r == ST_DONE)
      else $error("conversion exceeded 5 us");
   a_ignore_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r == ST_CONVERT && cs_fall && tmr_r != 8'(STEP_N - 1)) |=> st_r == ST_CONVERT)
      else $error("conversion disturbed");
   a_mode_pick: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r == ST_DONE) |=> st_r == ($past(cs_s2_r) ? ST_TRACK : ST_PDOWN))
      else $error("wrong power mode after conversion");
   a_early_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r == ST_WAKE && cs_fall) |-> ##[1:60] st_r == ST_CONVERT)
      else $error("early falling edge lost");
   a_result_load: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r == ST_DONE) |=> res_r.code == $past(sar_r) && ld_tgl_r != $past(ld_tgl_r))
      else $error("result not latched");
   a_sar_msb: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(st_r == ST_CONVERT) |-> sar_r == 8'h80)
      else $error("approximation not seeded");
   c_mode1: cover property (@(posedge core_clk) st_r == ST_DONE ##1 st_r == ST_TRACK);
   c_mode2: cover property (@(posedge core_clk) st_r == ST_DONE ##1 st_r == ST_PDOWN);
   c_early: cover property (@(posedge core_clk) st_r == ST_WAKE && cs_fall);
endmodule
`default_nettype wire

// ===== tb/adc_host_model.sv
// host model: drives the start pin and the serial clock
// assumes core_clk from the bench; sclk stands low outside reads
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
   input  wire logic core_clk,
   input  wire logic dout_o,
   input  wire logic dout_oe,
   output var logic  convert_start_n,
   output var logic  sclk
);
   initial begin
      convert_start_n = 1'b0;
      sclk = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic set_start(input logic lvl);
      repeat (4) @(posedge core_clk);
      convert_start_n <= lvl;
      repeat (4) @(posedge core_clk);
      #1;
   endtask
   // three sync pulses, then eight bits msb first
   task automatic read_byte(output logic [7:0] d, output logic oe_all,
                            output logic oe_any);
      d = 8'h00;
      oe_all = 1'b1;
      oe_any = 1'b0;
      #7;
      for (int i = 0; i < 11; i++) begin
         #62.5 sclk = 1'b1;
         #60;
         oe_any = oe_any | dout_oe;
         if (i > 2) begin
            d = {d[6:0], dout_o};
            oe_all = oe_all & dout_oe;
         end
         #2.5 sclk = 1'b0;
      end
      #10;
   endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the conversion and power sequencer
// assumes the host model drives start and sclk; comparator modelled here
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import adc_seq_pkg::*;
   logic       core_clk;
   logic       rst_n;
   logic       comparator_high;
   logic       convert_start_n;
   logic       sclk;
   logic       powered;
   logic       tracking;
   logic       dout_o;
   logic       dout_oe;
   logic [7:0] dac_code;
   logic [7:0] result_code;
   logic [7:0] vin;
   logic [7:0] d;
   logic       oa;
   logic       oy;
   int         err_count;
   int         check_count;
   adc_conversion_power_sequencer adc_conversion_power_sequencer_inst (
      .core_clk(core_clk), .rst_n(rst_n), .convert_start_n(convert_start_n),
      .comparator_high(comparator_high), .sclk(sclk), .powered(powered),
      .tracking(tracking), .dac_code(dac_code), .result_code(result_code),
      .dout_o(dout_o), .dout_oe(dout_oe));
   adc_host_model adc_host_model_inst (
      .core_clk(core_clk), .dout_o(dout_o), .dout_oe(dout_oe),
      .convert_start_n(convert_start_n), .sclk(sclk));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // comparator: high while trial code is above the input
   always @(posedge core_clk) begin
      comparator_high <= (dac_code > vin);
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic conv(input logic [7:0] v, input logic early, input logic glitch,
                       input logic stay);
      realtime t0;
      int      n;
      vin = v;
      if (convert_start_n === 1'b0) begin
         adc_host_model_inst.set_start(1'b1);
         if (!early) repeat (60) @(posedge core_clk);
         #1;
         check(powered === 1'b1, "not powered after wake");
      end
      adc_host_model_inst.set_start(1'b0);
      t0 = $realtime - 101.0;
      check(tracking === 1'b0, "hold phase wrong");
      if (!early) check(dac_code === 8'h80, "first trial not mid-scale");
      if (glitch) begin
         adc_host_model_inst.set_start(1'b1);
         adc_host_model_inst.set_start(1'b0);
      end
      if (stay) adc_host_model_inst.set_start(1'b1);
      n = 0;
      while (tracking !== 1'b0 && n < 100) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      while (tracking !== 1'b1 && n < 400) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      n = int'(($realtime - t0) / 25.0);
      check(n >= 195 + 55 * early && n <= 210 + 55 * early, "conversion time");
      @(posedge core_clk);
      #1;
      check(result_code === v, "wrong result");
      check(powered === stay, "power mode wrong");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      adc_host_model_inst.read_byte(d, oa, oy);
      check(powered === 1'b0 && result_code === 8'h00, "woke without rise");
      check(oy === 1'b0, "serial out before rise");
      $display("t_reset done");
   endtask
   task automatic t_auto_pd();
      logic [7:0] tbl[6] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h01, 8'h80};
      foreach (tbl[i]) conv(tbl[i], 1'b0, 1'b0, 1'b0);
      $display("t_auto_pd done");
   endtask
   task automatic t_high_speed();
      conv(8'h3C, 1'b0, 1'b0, 1'b1);
      conv(8'hC3, 1'b0, 1'b0, 1'b1);
      conv(8'h7E, 1'b0, 1'b0, 1'b0);
      $display("t_high_speed done");
   endtask
   task automatic t_early_fall();
      conv(8'h96, 1'b1, 1'b0, 1'b0);
      $display("t_early_fall done");
   endtask
   task automatic t_ignore_fall();
      conv(8'h69, 1'b0, 1'b1, 1'b0);
      $display("t_ignore_fall done");
   endtask
   task automatic t_serial();
      adc_host_model_inst.set_start(1'b1);
      adc_host_model_inst.read_byte(d, oa, oy);
      check(d === 8'h69 && oa === 1'b1, "serial byte wrong");
      check(dout_oe === 1'b0, "output not released");
      adc_host_model_inst.read_byte(d, oa, oy);
      check(oy === 1'b0, "second read drove output");
      $display("t_serial done");
   endtask
   task automatic t_mid_reset();
      adc_host_model_inst.set_start(1'b0);
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
      check(powered === 1'b0 && tracking === 1'b0 && result_code === 8'h00, "not reset");
      @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      check(powered === 1'b0 && tracking === 1'b1, "woke after reset");
      conv(8'h5A, 1'b0, 1'b0, 1'b0);
      $display("t_mid_reset done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      vin = 8'h00;
      comparator_high = 1'b0;
      err_count = 0;
      check_count = 0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_auto_pd();
      t_high_speed();
      t_early_fall();
      t_ignore_fall();
      t_serial();
      t_mid_reset();
      summarize();
   end
   // watchdog: tests need about 3400 cycles
   initial begin
      #(20000 * 25);
      err_count++;
      $display("[ERR] %0t watchdog expired", $time);
      summarize();
   end
endmodule
`default_nettype wire
